//--- rtd_scale_pkg.sv
// Operation
// - Bit 15 of each channel's configuration word enables or disables that channel.
// - Only enabled channels are scanned; disabled channels are skipped entirely.
// - A channel newly enabled is recalibrated before any measured data is produced.
// - A disabled channel's data word is forced to zero.
// - Bits 12 to 14 select the channel data presentation format.
// - Raw format maps range low to -32767 and range high to +32767.
// - Engineering x1: RTD in 0.1 degree steps, resistance in 0.01 ohm steps for 150 ohm, 0.1 ohm steps otherwise.
// - Engineering x10: RTD in whole degrees, resistance in 0.1 ohm steps for 150 ohm, whole ohms otherwise.
// - Engineering formats are bounded per sensor type, e.g. Pt385 x1 C -2000..8500.
// - Scaled-for-PID maps range low to 0 and range high to +16383.
// - Percent format maps the range onto 0 through +10000.
// - Bits 8 to 11 select the sensor or resistance type per channel.
// - Bit 7 picks C or F; ignored for resistance and non-engineering formats.
// - On open circuit the measured value is replaced by a substitute from bits 5-6.
// - Substitute is upper scale, lower scale, last valid value, or zero.
// - Bit 4 low enables cyclic lead compensation, once every 6 module scans.
// - Lead resistance is measured on only one channel per module update, rotating.
// - Setting bit 4 to enable then back to disable triggers one lead calibration.
// - Program-to-run change or any online channel change forces lead compensation.
// - Format codes: 000 raw, 001 eng x1, 100 eng x10, 010 PID, 011 percent.
// - Type codes 0 to 11 are RTD sensors; 12 to 15 are 150/500/1000/3000 ohm.
// - Enable bit 0 means enabled; unit bit 0 means Celsius, 1 Fahrenheit.
// - Open-circuit codes: 00 upscale, 01 downscale, 10 last state, 11 zero.
package rtd_scale_pkg;

    localparam int ADDR_W = 5;
    localparam int CH_W = 3;

    localparam logic [ADDR_W-1:0] CFG_BASE = 5'h00;
    localparam logic [ADDR_W-1:0] DATA_BASE = 5'h08;
    localparam logic [ADDR_W-1:0] STAT_ADDR = 5'h10;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 5'h11;

    localparam logic [15:0] CFG_RST = 16'h8000;
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [15:0] POS_FULL = 16'hFFFF;

    localparam logic [2:0] FMT_RAW = 3'h0;
    localparam logic [2:0] FMT_ENG1 = 3'h1;
    localparam logic [2:0] FMT_ENG10 = 3'h4;
    localparam logic [2:0] FMT_PID = 3'h2;
    localparam logic [2:0] FMT_PCT = 3'h3;

    localparam logic [1:0] OC_UP = 2'h0;
    localparam logic [1:0] OC_DOWN = 2'h1;
    localparam logic [1:0] OC_LAST = 2'h2;
    localparam logic [1:0] OC_ZERO = 2'h3;

    // Channel configuration word, bit 15 first
    typedef struct packed {
        logic dis;
        logic [2:0] fmt;
        logic [3:0] typ;
        logic fahr;
        logic [1:0] oc;
        logic lead_off;
        logic unused;
        logic [2:0] filt;
    } cfg_t;

    typedef struct packed {
        logic signed [15:0] lo;
        logic signed [15:0] hi;
    } range_t;

    // Request to the converter front end
    typedef struct packed {
        logic [CH_W-1:0] chan;
        logic cal;
        logic lead;
    } conv_req_t;

    // Result from the front end: position 0 = range low, FFFF = range high
    typedef struct packed {
        logic [CH_W-1:0] chan;
        logic [15:0] pos;
        logic open_ckt;
    } sample_t;

    // Engineering bounds; x10 is the x1 table divided by ten
    function automatic range_t eng_range(input logic [3:0] typ, input logic f,
                                         input logic x10);
        range_t r;
        r = '{lo: 16'sh0000, hi: 16'sh0000};
        case (typ)
            4'h0, 4'h1, 4'h2, 4'h3:
                r = x10 ? (f ? '{-16'sd328, 16'sd1562} : '{-16'sd200, 16'sd850})
                        : (f ? '{-16'sd3280, 16'sd15620} : '{-16'sd2000, 16'sd8500});
            4'h4, 4'h5, 4'h6, 4'h7:
                r = x10 ? (f ? '{-16'sd328, 16'sd1166} : '{-16'sd200, 16'sd630})
                        : (f ? '{-16'sd3280, 16'sd11660} : '{-16'sd2000, 16'sd6300});
            4'h8, 4'h9:
                r = x10 ? (f ? '{-16'sd148, 16'sd500} : '{-16'sd100, 16'sd260})
                        : (f ? '{-16'sd1480, 16'sd5000} : '{-16'sd1000, 16'sd2600});
            4'hA:
                r = x10 ? (f ? '{-16'sd112, 16'sd500} : '{-16'sd80, 16'sd260})
                        : (f ? '{-16'sd1120, 16'sd5000} : '{-16'sd800, 16'sd2600});
            4'hB:
                r = x10 ? (f ? '{-16'sd148, 16'sd392} : '{-16'sd100, 16'sd200})
                        : (f ? '{-16'sd1480, 16'sd3920} : '{-16'sd1000, 16'sd2000});
            4'hC: r = x10 ? '{16'sd0, 16'sd1500} : '{16'sd0, 16'sd15000};
            4'hD: r = x10 ? '{16'sd0, 16'sd500} : '{16'sd0, 16'sd5000};
            4'hE: r = x10 ? '{16'sd0, 16'sd1000} : '{16'sd0, 16'sd10000};
            4'hF: r = x10 ? '{16'sd0, 16'sd3000} : '{16'sd0, 16'sd30000};
            default: r = '{lo: 16'sh0000, hi: 16'sh0000};
        endcase
        return r;
    endfunction : eng_range

    // Output span for a channel's format, type and unit
    function automatic range_t chan_range(input cfg_t c);
        range_t r;
        logic f;
        f = c.fahr & ~c.typ[3] | c.fahr & ~c.typ[2];
        case (c.fmt)
            FMT_ENG1: r = eng_range(c.typ, f, 1'b0);
            FMT_ENG10: r = eng_range(c.typ, f, 1'b1);
            FMT_PID: r = '{lo: 16'sh0000, hi: 16'sh3FFF};
            FMT_PCT: r = '{lo: 16'sh0000, hi: 16'sh2710};
            default: r = '{lo: 16'sh8001, hi: 16'sh7FFF};
        endcase
        return r;
    endfunction : chan_range

endpackage : rtd_scale_pkg

//--- rtd_channel_config_and_scaling.sv
`timescale 1ns/100ps
module rtd_channel_config_and_scaling
    import rtd_scale_pkg::*;
#(
    parameter int NUM_CH = 6
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    output logic conv_vld_o,
    output conv_req_t conv_o,
    input wire logic smp_vld_i,
    input wire sample_t smp_i
);

    typedef enum logic {S_PICK, S_WAIT} state_t;

    state_t st_q, st_d;
    cfg_t cfg_q [NUM_CH];
    logic signed [15:0] data_q [NUM_CH];
    logic [NUM_CH-1:0] cal_pend_q, lead_pend_q, open_q;
    logic [CH_W-1:0] chan_q, rotor_q;
    logic lead_used_q, run_q;
    logic [15:0] rdata_q;
    logic conv_vld_q;
    conv_req_t conv_q;

    // Bus decode
    wire cfg_hit = addr_i[ADDR_W-1:CH_W] == CFG_BASE[ADDR_W-1:CH_W]
                   && 32'(addr_i[CH_W-1:0]) < NUM_CH;
    wire data_hit = addr_i[ADDR_W-1:CH_W] == DATA_BASE[ADDR_W-1:CH_W]
                    && 32'(addr_i[CH_W-1:0]) < NUM_CH;
    wire [CH_W-1:0] idx = addr_i[CH_W-1:0];
    wire cfg_wr = wr_i && cfg_hit;
    wire ctrl_wr = wr_i && addr_i == CTRL_ADDR;
    wire cfg_t new_cfg = cfg_t'(wdata_i);
    wire cfg_t old_cfg = cfg_q[idx];
    wire en_edge = cfg_wr && old_cfg.dis && !new_cfg.dis;
    wire cfg_change = cfg_wr && new_cfg != old_cfg;
    wire lead_trig = cfg_wr && !old_cfg.lead_off && new_cfg.lead_off;
    wire run_edge = ctrl_wr && !run_q && wdata_i[0];

    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        if (cfg_hit) begin
            rd_mux = cfg_q[idx];
        end else if (data_hit) begin
            rd_mux = data_q[idx];
        end else if (addr_i == STAT_ADDR) begin
            rd_mux = {2'h0, cal_pend_q, 2'h0, open_q};
        end else if (addr_i == CTRL_ADDR) begin
            rd_mux = {15'h0000, run_q};
        end
    end

    // Scan sequencing
    wire cfg_t cur_cfg = cfg_q[chan_q];
    wire cur_en = !cur_cfg.dis;
    wire scan_end = 32'(chan_q) == NUM_CH - 1;
    wire [CH_W-1:0] chan_nxt = scan_end ? '0 : chan_q + 3'h1;
    wire issue = st_q == S_PICK && cur_en;
    wire lead_now = !lead_used_q && (lead_pend_q[chan_q]
                    || (!cur_cfg.lead_off && rotor_q == chan_q));
    wire take = st_q == S_WAIT && smp_vld_i && smp_i.chan == chan_q;
    wire advance = (st_q == S_PICK && !cur_en) || take;
    wire scan_done = advance && scan_end;

    always_comb begin
        st_d = st_q;
        case (st_q)
            S_PICK: if (issue) st_d = S_WAIT;
            S_WAIT: if (take) st_d = S_PICK;
            default: st_d = S_PICK;
        endcase
    end

    // Scaling of the converter position onto the format span
    wire range_t rng = chan_range(cur_cfg);
    wire signed [17:0] span = 18'(rng.hi) - 18'(rng.lo);
    wire [16:0] pos_x = {1'b0, smp_i.pos} + 17'(smp_i.pos[15]);
    wire signed [35:0] prod = span * $signed({1'b0, pos_x});
    wire signed [17:0] sum = 18'(rng.lo) + $signed({1'b0, prod[33:17]}) * 18'sd2
                             + 18'(prod[16]);
    wire [15:0] scaled = sum[15:0];

    // Open-circuit substitute
    logic [15:0] sub_val;
    always_comb begin
        case (cur_cfg.oc)
            OC_UP: sub_val = rng.hi;
            OC_DOWN: sub_val = rng.lo;
            OC_LAST: sub_val = data_q[chan_q];
            default: sub_val = 16'h0000;
        endcase
    end

    wire keep = cal_pend_q[chan_q];
    wire [15:0] new_data = smp_i.open_ckt ? sub_val : scaled;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= S_PICK;
            chan_q <= '0;
            rotor_q <= '0;
            lead_used_q <= 1'b0;
            run_q <= 1'b0;
        end else begin
            st_q <= st_d;
            chan_q <= advance ? chan_nxt : chan_q;
            if (scan_done) begin
                rotor_q <= 32'(rotor_q) == NUM_CH - 1 ? '0 : rotor_q + 3'h1;
                lead_used_q <= 1'b0;
            end else if (issue && lead_now) begin
                lead_used_q <= 1'b1;
            end
            if (ctrl_wr) run_q <= wdata_i[0];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            conv_vld_q <= 1'b0;
            conv_q <= '0;
            rdata_q <= 16'h0000;
        end else begin
            conv_vld_q <= issue;
            if (issue) conv_q <= '{chan: chan_q, cal: keep, lead: lead_now};
            rdata_q <= rd_i ? rd_mux : 16'h0000;
        end
    end

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        wire sel_w = cfg_wr && idx == CH_W'(i);
        wire here = take && chan_q == CH_W'(i);
        wire lead_clr = issue && lead_now && chan_q == CH_W'(i);
        wire lead_set = (sel_w && (cfg_change || lead_trig)) || run_edge;
        always_ff @(posedge core_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                cfg_q[i] <= cfg_t'(CFG_RST);
                data_q[i] <= DATA_RST;
                cal_pend_q[i] <= 1'b0;
                lead_pend_q[i] <= 1'b0;
                open_q[i] <= 1'b0;
            end else begin
                if (sel_w) cfg_q[i] <= new_cfg;
                // Set wins over clear so a fresh enable is never lost
                // Only a sample that was asked for as calibration may clear the flag
                cal_pend_q[i] <= (cal_pend_q[i] && !(here && conv_q.cal))
                                 || (sel_w && en_edge);
                lead_pend_q[i] <= (lead_pend_q[i] && !lead_clr) || lead_set;
                if ((sel_w && new_cfg.dis) || cfg_q[i].dis) begin
                    data_q[i] <= 16'h0000;
                    open_q[i] <= 1'b0;
                end else if (here && !keep) begin
                    data_q[i] <= new_data;
                    open_q[i] <= smp_i.open_ckt;
                end
            end
        end
    end

    assign rdata_o = rdata_q;
    assign conv_vld_o = conv_vld_q;
    assign conv_o = conv_q;

    dis_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        cfg_wr && new_cfg.dis |=> data_q[$past(idx)] == 16'h0000)
        else $error("disabled channel data not zero");

    skip_dis_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        conv_vld_q |-> $past(!cfg_q[chan_q].dis) && $past(chan_q) == conv_q.chan)
        else $error("disabled channel was scanned");

    cal_first_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        en_edge |=> cal_pend_q[$past(idx)] ##0 (!conv_vld_q || conv_q.chan != $past(idx)
        || conv_q.cal))
        else $error("enabled channel not recalibrated first");

    lead_once_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        conv_vld_q && conv_q.lead |-> !$past(lead_used_q))
        else $error("second lead measurement in one scan");

    raw_top_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        take && !keep && !cur_cfg.dis && !smp_i.open_ckt && cur_cfg.fmt == FMT_RAW
        && smp_i.pos == POS_FULL && !cfg_wr |=> data_q[$past(chan_q)] == 16'h7FFF)
        else $error("raw full scale not 32767");

    pid_span_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        take && !keep && !cur_cfg.dis && !smp_i.open_ckt && cur_cfg.fmt == FMT_PID
        && !cfg_wr |=> $signed(data_q[$past(chan_q)]) inside {[0:16383]})
        else $error("PID value out of span");

    pct_low_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        take && !keep && !cur_cfg.dis && !smp_i.open_ckt && cur_cfg.fmt == FMT_PCT
        && smp_i.pos == 16'h0000 && !cfg_wr |=> data_q[$past(chan_q)] == 16'h0000)
        else $error("percent low end not zero");

    open_sub_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        take && !keep && !cur_cfg.dis && smp_i.open_ckt && cur_cfg.oc == OC_UP
        && !cfg_wr |=> data_q[$past(chan_q)] == $past(rng.hi))
        else $error("open circuit upscale not applied");

    run_lead_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        run_edge |=> &lead_pend_q)
        else $error("run entry did not request lead compensation");

    dis_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        cur_cfg.dis |-> data_q[chan_q] == 16'h0000)
        else $error("disabled channel holds data");

    raw_low_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        take && !keep && !cur_cfg.dis && !smp_i.open_ckt && cur_cfg.fmt == FMT_RAW
        && smp_i.pos == 16'h0000 && !cfg_wr |=> data_q[$past(chan_q)] == 16'h8001)
        else $error("raw low end not -32767");

    pid_low_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        take && !keep && !cur_cfg.dis && !smp_i.open_ckt && cur_cfg.fmt == FMT_PID
        && smp_i.pos == 16'h0000 && !cfg_wr |=> data_q[$past(chan_q)] == 16'h0000)
        else $error("PID low end not zero");

    pct_top_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        take && !keep && !cur_cfg.dis && !smp_i.open_ckt && cur_cfg.fmt == FMT_PCT
        && smp_i.pos == POS_FULL && !cfg_wr |=> data_q[$past(chan_q)] == 16'h2710)
        else $error("percent top not 10000");

    open_down_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        take && !keep && !cur_cfg.dis && smp_i.open_ckt && cur_cfg.oc == OC_DOWN
        && !cfg_wr |=> data_q[$past(chan_q)] == $past(rng.lo))
        else $error("open circuit downscale not applied");

    open_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        take && !keep && !cur_cfg.dis && smp_i.open_ckt && cur_cfg.oc == OC_ZERO
        && !cfg_wr |=> data_q[$past(chan_q)] == 16'h0000)
        else $error("open circuit zero not applied");

    cal_drop_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        take && keep && !cur_cfg.dis && !cfg_wr
        |=> data_q[$past(chan_q)] == $past(data_q[chan_q]))
        else $error("calibration sample reached data word");

    eng_bound_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        take && !keep && !cur_cfg.dis && !smp_i.open_ckt && !cfg_wr
        && (cur_cfg.fmt == FMT_ENG1 || cur_cfg.fmt == FMT_ENG10)
        |=> $signed(data_q[$past(chan_q)]) >= $past(rng.lo)
        && $signed(data_q[$past(chan_q)]) <= $past(rng.hi))
        else $error("engineering value out of bounds");

endmodule : rtd_channel_config_and_scaling

//--- rtd_front_end_model.sv
`timescale 1ns/100ps
module rtd_front_end_model
    import rtd_scale_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic conv_vld_i,
    input wire conv_req_t conv_i,
    input wire logic [7:0] lat_i,
    input wire logic [15:0] pos_i,
    input wire logic open_i,
    output logic smp_vld_o,
    output sample_t smp_o
);
    logic [7:0] wait_q;
    logic busy_q;
    logic [CH_W-1:0] chan_q;

    // Idle bus toggles so a stale sample never looks valid
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_q <= 1'b0;
            wait_q <= 8'h00;
            chan_q <= '0;
            smp_vld_o <= 1'b0;
            smp_o <= '0;
        end else begin
            smp_vld_o <= 1'b0;
            smp_o <= ~smp_o;
            if (conv_vld_i) begin
                busy_q <= 1'b1;
                wait_q <= lat_i;
                chan_q <= conv_i.chan;
            end else if (busy_q && wait_q == 8'h00) begin
                busy_q <= 1'b0;
                smp_vld_o <= 1'b1;
                smp_o <= '{chan: chan_q, pos: pos_i, open_ckt: open_i};
            end else if (busy_q) begin
                wait_q <= wait_q - 8'h01;
            end
        end
    end
endmodule : rtd_front_end_model

//--- rtd_channel_config_and_scaling_test.sv
`timescale 1ns/100ps
module rtd_channel_config_and_scaling_test
    import rtd_scale_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic conv_vld;
    conv_req_t conv;
    logic smp_vld;
    sample_t smp;
    logic [7:0] lat = 8'h03;
    logic [15:0] pos = 16'h0000;
    logic open_c = 1'b0;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int req_cnt[6] = '{default: 0};
    int cal_cnt[6] = '{default: 0};
    int lead_cnt[6] = '{default: 0};
    int scan_lead = 0;
    int max_lead = 0;
    logic [15:0] v;
    logic [15:0] f_cfg[9] = '{16'h1010, 16'h1010, 16'h4090, 16'h1F90, 16'h0010,
                              16'h0010, 16'h2090, 16'h3010, 16'h4C10};
    logic [15:0] f_pos[9] = '{16'h0000, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0000,
                              16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
    logic [15:0] f_exp[9] = '{16'hF830, 16'h2134, 16'h061A, 16'h7530, 16'h8001,
                              16'h7FFF, 16'h3FFF, 16'h2710, 16'h05DC};
    logic [1:0] oc_code[4] = '{OC_LAST, OC_UP, OC_DOWN, OC_ZERO};
    logic [15:0] oc_exp[4] = '{16'hF830, 16'h2134, 16'hF830, 16'h0000};

    rtd_channel_config_and_scaling #(.NUM_CH(6)) dut (
        .core_clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .conv_vld_o(conv_vld),
        .conv_o(conv), .smp_vld_i(smp_vld), .smp_i(smp));
    rtd_front_end_model fe (
        .clk_i(clk), .rst_b_i(rst_b), .conv_vld_i(conv_vld), .conv_i(conv),
        .lat_i(lat), .pos_i(pos), .open_i(open_c), .smp_vld_o(smp_vld), .smp_o(smp));

    always #50 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            conclude();
        end
        if (conv_vld && conv.chan < 3'h6) begin
            if (conv.chan == 3'h0) scan_lead = 0;
            req_cnt[conv.chan]++;
            if (conv.cal) cal_cnt[conv.chan]++;
            if (conv.lead) begin
                lead_cnt[conv.chan]++;
                scan_lead++;
                if (scan_lead > max_lead) max_lead = scan_lead;
            end
        end
    end

    task automatic conclude();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg

    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [15:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge clk);
    endtask : rd_reg

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    function automatic int lead_sum();
        return lead_cnt[0] + lead_cnt[1] + lead_cnt[2] + lead_cnt[3] + lead_cnt[4] + lead_cnt[5];
    endfunction : lead_sum

    task automatic t_reset();
        rd_reg(CFG_BASE, v);
        chk(v, 16'h8000);
        rd_reg(DATA_BASE, v);
        chk(v, 16'h0000);
        rd_reg(5'h1F, v);
        chk(v, 16'h0000);
    endtask : t_reset

    task automatic t_formats();
        for (int i = 0; i < 9; i++) begin
            pos <= f_pos[i];
            wr_reg(CFG_BASE, f_cfg[i]);
            idle(80);
            rd_reg(DATA_BASE, v);
            chk(v, f_exp[i]);
        end
    endtask : t_formats

    task automatic t_open();
        pos <= 16'h0000;
        wr_reg(CFG_BASE, 16'h1010);
        idle(80);
        open_c <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr_reg(CFG_BASE, 16'h1010 | {9'h000, oc_code[i], 5'h00});
            idle(80);
            rd_reg(DATA_BASE, v);
            chk(v, oc_exp[i]);
        end
        rd_reg(STAT_ADDR, v);
        chk(v & 16'h0001, 16'h0001);
        open_c <= 1'b0;
        wr_reg(CFG_BASE, 16'h1010);
        idle(80);
    endtask : t_open

    task automatic t_disable();
        int snap;
        wr_reg(CFG_BASE, 16'h9010);
        rd_reg(DATA_BASE, v);
        chk(v, 16'h0000);
        snap = req_cnt[0];
        idle(100);
        chk(16'(req_cnt[0] - snap), 16'h0000);
    endtask : t_disable

    task automatic t_recal();
        int snap;
        snap = cal_cnt[1];
        pos <= 16'hFFFF;
        wr_reg(CFG_BASE + 5'h01, 16'h3010);
        idle(100);
        chk(16'(cal_cnt[1] - snap), 16'h0001);
        rd_reg(DATA_BASE + 5'h01, v);
        chk(v, 16'h2710);
    endtask : t_recal

    task automatic t_lead();
        int snap;
        lat <= 8'h0A;
        for (int c = 0; c < 6; c++) wr_reg(CFG_BASE + 5'(c), 16'h1000);
        max_lead = 0;
        idle(1500);
        for (int c = 0; c < 6; c++) chk({15'h0000, lead_cnt[c] > 0}, 16'h0001);
        chk(16'(max_lead), 16'h0001);
        for (int c = 0; c < 6; c++) wr_reg(CFG_BASE + 5'(c), 16'h1010);
        idle(800);
        snap = lead_sum();
        idle(800);
        chk(16'(lead_sum() - snap), 16'h0000);
        snap = lead_cnt[3];
        wr_reg(CFG_BASE + 5'h03, 16'h1000);
        wr_reg(CFG_BASE + 5'h03, 16'h1010);
        idle(500);
        chk({15'h0000, lead_cnt[3] > snap}, 16'h0001);
        snap = lead_sum();
        wr_reg(CTRL_ADDR, 16'h0000);
        wr_reg(CTRL_ADDR, 16'h0001);
        idle(800);
        chk({15'h0000, lead_sum() > snap}, 16'h0001);
    endtask : t_lead

    initial begin
        idle(4);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset();
        wr_reg(CTRL_ADDR, 16'h0001);
        t_formats();
        t_open();
        t_disable();
        t_recal();
        t_lead();
        conclude();
    end
endmodule : rtd_channel_config_and_scaling_test
